// [hw/sfcd_pkg.sv]
// shared opcodes, command kinds, phases and reset values of the flash command decoder
package sfcd_pkg;

  // opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ_ID = 8'h9f;
  localparam logic [7:0] OP_RD_NORM = 8'h03;
  localparam logic [7:0] OP_RD_FAST = 8'h0b;
  localparam logic [7:0] OP_RD_DUAL = 8'hbb;
  localparam logic [7:0] OP_RD_QUAD = 8'heb;
  localparam logic [7:0] OP_PROG_PAGE = 8'h02;
  localparam logic [7:0] OP_PROG_QUAD = 8'h38;
  localparam logic [7:0] OP_WIPE_SMALL = 8'h20;
  localparam logic [7:0] OP_WIPE_64K = 8'hd8;
  localparam logic [7:0] OP_WIPE_32K = 8'h52;
  localparam logic [7:0] OP_WIPE_ALL_A = 8'h60;
  localparam logic [7:0] OP_WIPE_ALL_B = 8'hc7;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_SIG = 8'hab;
  localparam logic [7:0] OP_IDP_1 = 8'h90;
  localparam logic [7:0] OP_IDP_2 = 8'hef;
  localparam logic [7:0] OP_IDP_4 = 8'hdf;

  // cycle counts of the command phases
  localparam logic [5:0] CYC_ADDR_1 = 6'h18;
  localparam logic [5:0] CYC_ADDR_2 = 6'h0c;
  localparam logic [5:0] CYC_ADDR_4 = 6'h06;
  localparam logic [5:0] CYC_DUM_FAST = 6'h08;
  localparam logic [5:0] CYC_DUM_DUAL = 6'h04;
  localparam logic [5:0] CYC_DUM_QUAD = 6'h06; // 2 indicator + 4 dummy
  localparam logic [5:0] CYC_DUM_SIG = 6'h18;

  // lane widths
  localparam logic [2:0] LW0 = 3'h0;
  localparam logic [2:0] LW1 = 3'h1;
  localparam logic [2:0] LW2 = 3'h2;
  localparam logic [2:0] LW4 = 3'h4;

  // status byte layout and reset value
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_QE = 6;
  localparam int ST_SRWD = 7;
  localparam logic [3:0] BP_RST = 4'hf;
  localparam logic LOCK_ALL_RST = 1'b1;
  localparam int FIFO_DEPTH = 16;

  // decoded command kinds
  typedef enum logic [4:0] {
    K_NONE, K_SET_LATCH, K_CLR_LATCH, K_STAT_RD, K_STAT_WR, K_READ_ID,
    K_RD_NORM, K_RD_FAST, K_RD_DUAL, K_RD_QUAD, K_PROG_PAGE, K_PROG_QUAD,
    K_WIPE_SMALL, K_WIPE_64K, K_WIPE_32K, K_WIPE_ALL, K_SLEEP, K_WAKE_SIG,
    K_IDP_1, K_IDP_2, K_IDP_4
  } sfcd_kind_t;

  // link phases, one-hot
  typedef enum logic [5:0] {
    PH_CMD = 6'h01,
    PH_ADDR = 6'h02,
    PH_DUMMY = 6'h04,
    PH_DIN = 6'h08,
    PH_DOUT = 6'h10,
    PH_STBY = 6'h20
  } sfcd_phase_t;

  // shape of one command
  typedef struct packed {
    logic ok;
    sfcd_kind_t kind;
    logic [5:0] addrCyc;
    logic [2:0] addrW;
    logic [5:0] dumCyc;
    logic [2:0] dinW;
    logic [2:0] doutW;
  } sfcd_info_t;

  // phase to enter and its cycle count
  typedef struct packed {
    sfcd_phase_t ph;
    logic [5:0] cnt;
  } sfcd_step_t;

endpackage : sfcd_pkg

// [hw/sfcd_stream_if.sv]
// valid/ready byte stream between the decoder and its fifo
`timescale 1ns/1ps
interface sfcd_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data; // payload
  logic valid; // source holds a word
  logic ready; // sink takes it

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sfcd_stream_if

// [hw/sfcd_sync.sv]
// two-flop synchroniser for quasi-static levels
`timescale 1ns/1ps
module sfcd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] metaQ; // first stage, read only by q

  // plain double register, reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      metaQ <= '0;
      q <= '0;
    end else begin
      metaQ <= d;
      q <= metaQ;
    end
  end
endmodule : sfcd_sync

// [hw/sfcd_fifo.sv]
// dual-clock fifo with gray pointers and a registered read stage
`timescale 1ns/1ps
module sfcd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic wrClk,
  input wire logic wrRst,
  sfcd_stream_if.snk wr,
  input wire logic rdClk,
  input wire logic rdRst,
  sfcd_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  // binary to gray, used on both sides
  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : toGray

  logic [W-1:0] mem [DEPTH]; // storage
  logic [AW:0] wrBinQ, wrGrayQ, rdBinQ, rdGrayQ; // own pointers
  logic [AW:0] rdGrayS, wrGrayS; // pointers seen across
  logic [W-1:0] outDataQ; // read stage
  logic outValidQ;

  wire logic [AW:0] wrBinD = wrBinQ + 1'b1;
  wire logic [AW:0] rdBinD = rdBinQ + 1'b1;
  // full when gray pointers differ only in the two top bits
  wire logic full = wrGrayQ == {~rdGrayS[AW:AW-1], rdGrayS[AW-2:0]};
  wire logic empty = rdGrayQ == wrGrayS;
  wire logic push = wr.valid & ~full;
  // refill the read stage when it is free or being taken
  wire logic pop = ~empty & (~outValidQ | rd.ready);

  assign wr.ready = ~full;
  assign rd.valid = outValidQ;
  assign rd.data = outDataQ;

  sfcd_sync #(.W(AW + 1)) uRdToWr (.clk(wrClk), .rst(wrRst), .d(rdGrayQ), .q(rdGrayS));
  sfcd_sync #(.W(AW + 1)) uWrToRd (.clk(rdClk), .rst(rdRst), .d(wrGrayQ), .q(wrGrayS));

  // storage write, no reset needed
  always_ff @(posedge wrClk) begin
    if (push) begin
      mem[wrBinQ[AW-1:0]] <= wr.data;
    end
  end

  // write pointer
  always_ff @(posedge wrClk or posedge wrRst) begin
    if (wrRst) begin
      wrBinQ <= '0;
      wrGrayQ <= '0;
    end else if (push) begin
      wrBinQ <= wrBinD;
      wrGrayQ <= toGray(wrBinD);
    end
  end

  // read pointer and output stage
  always_ff @(posedge rdClk or posedge rdRst) begin
    if (rdRst) begin
      rdBinQ <= '0;
      rdGrayQ <= '0;
      outValidQ <= 1'b0;
      outDataQ <= '0;
    end else begin
      if (pop) begin
        rdBinQ <= rdBinD;
        rdGrayQ <= toGray(rdBinD);
        outDataQ <= mem[rdBinQ[AW-1:0]];
      end
      if (pop) begin
        outValidQ <= 1'b1;
      end else if (rd.ready) begin
        outValidQ <= 1'b0;
      end
    end
  end
endmodule : sfcd_fifo

// [hw/sfcd_top.sv]
// serial flash command decoder: link-side sequencer and core-side command commit
// Summary of operation
// - latch set/clear bare; status write eight bits
// - status read streams the status byte
// - id read: maker byte then two device bytes
// - normal read 24 address; fast adds 8 dummy
// - dual 12 address 4 dummy; quad 6+2+4
// - page program: 24 address then data bytes
// - quad program: 6 address, four-line data
// - 64k wipe with address; whole wipe bare
// - 32k and small wipe take 24 address
// - wake opcode; 24 dummy then signature byte
// - id pair reads on one, two, four lines
// - address bit zero picks which id first
// - all blocks come up locked
// - sample on rising edge, drive on falling
// - writing commands need byte-aligned deselect
// - unknown opcode: output off until deselect
// - writing commands need the write latch set
`timescale 1ns/1ps
module sfcd_top import sfcd_pkg::*; #(
  parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] MEM_TYPE_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h13, // arbitrary value
  parameter logic [7:0] SIG_ID = 8'h12 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] sioIn,
  output logic [3:0] sioOut,
  output logic [3:0] sioOe,
  output logic [23:0] memAddr,
  input wire logic [7:0] memRdData,
  output logic [7:0] progData,
  output logic progValid,
  input wire logic progReady,
  output logic progDrop,
  output logic actValid,
  output logic [4:0] actKind,
  output logic [23:0] actAddr,
  input wire logic actDone,
  output logic busy,
  output logic deepSleep,
  output logic blocksLocked
);

  // opcode table; in deep sleep only the wake opcode is known
  function automatic sfcd_info_t cmdDecode(input logic [7:0] op, input logic asleep);
    sfcd_info_t i;
    i = '0;
    i.ok = 1'b1;
    i.addrW = LW1;
    unique case (op)
      OP_SET_LATCH: i.kind = K_SET_LATCH;
      OP_CLR_LATCH: i.kind = K_CLR_LATCH;
      OP_STAT_WR: begin i.kind = K_STAT_WR; i.dinW = LW1; end
      OP_STAT_RD: begin i.kind = K_STAT_RD; i.doutW = LW1; end
      OP_READ_ID: begin i.kind = K_READ_ID; i.doutW = LW1; end
      OP_RD_NORM: begin i.kind = K_RD_NORM; i.addrCyc = CYC_ADDR_1; i.doutW = LW1; end
      OP_RD_FAST: begin
        i.kind = K_RD_FAST; i.addrCyc = CYC_ADDR_1; i.dumCyc = CYC_DUM_FAST; i.doutW = LW1;
      end
      OP_RD_DUAL: begin
        i.kind = K_RD_DUAL; i.addrCyc = CYC_ADDR_2; i.addrW = LW2;
        i.dumCyc = CYC_DUM_DUAL; i.doutW = LW2;
      end
      OP_RD_QUAD: begin
        i.kind = K_RD_QUAD; i.addrCyc = CYC_ADDR_4; i.addrW = LW4;
        i.dumCyc = CYC_DUM_QUAD; i.doutW = LW4;
      end
      OP_PROG_PAGE: begin i.kind = K_PROG_PAGE; i.addrCyc = CYC_ADDR_1; i.dinW = LW1; end
      OP_PROG_QUAD: begin
        i.kind = K_PROG_QUAD; i.addrCyc = CYC_ADDR_4; i.addrW = LW4; i.dinW = LW4;
      end
      OP_WIPE_64K: begin i.kind = K_WIPE_64K; i.addrCyc = CYC_ADDR_1; end
      OP_WIPE_ALL_A, OP_WIPE_ALL_B: i.kind = K_WIPE_ALL;
      OP_WIPE_32K: begin i.kind = K_WIPE_32K; i.addrCyc = CYC_ADDR_1; end
      OP_WIPE_SMALL: begin i.kind = K_WIPE_SMALL; i.addrCyc = CYC_ADDR_1; end
      OP_SLEEP: i.kind = K_SLEEP;
      OP_WAKE_SIG: begin i.kind = K_WAKE_SIG; i.dumCyc = CYC_DUM_SIG; i.doutW = LW1; end
      OP_IDP_1: begin i.kind = K_IDP_1; i.addrCyc = CYC_ADDR_1; i.doutW = LW1; end
      OP_IDP_2: begin i.kind = K_IDP_2; i.addrCyc = CYC_ADDR_1; i.doutW = LW2; end
      OP_IDP_4: begin i.kind = K_IDP_4; i.addrCyc = CYC_ADDR_1; i.doutW = LW4; end
      default: i = '0;
    endcase
    if (asleep && op != OP_WAKE_SIG) begin
      i = '0;
    end
    return i;
  endfunction : cmdDecode

  // phase that follows a finished stage: 0 opcode, 1 address, 2 dummy
  function automatic sfcd_step_t nextStep(input sfcd_info_t i, input logic [1:0] from);
    sfcd_step_t s;
    s.ph = PH_STBY;
    s.cnt = '0;
    if (from == 2'd0 && i.addrCyc != '0) begin
      s.ph = PH_ADDR;
      s.cnt = i.addrCyc;
    end else if (from <= 2'd1 && i.dumCyc != '0) begin
      s.ph = PH_DUMMY;
      s.cnt = i.dumCyc;
    end else if (i.dinW != LW0) begin
      s.ph = PH_DIN;
    end else if (i.doutW != LW0) begin
      s.ph = PH_DOUT;
    end
    return s;
  endfunction : nextStep

  // shift w input lanes in at the bottom, lane 0 is the least significant
  function automatic logic [23:0] shiftIn(input logic [23:0] r, input logic [3:0] s,
                                          input logic [2:0] w);
    logic [23:0] v;
    v = {r[22:0], s[0]};
    if (w == LW2) begin
      v = {r[21:0], s[1:0]};
    end else if (w == LW4) begin
      v = {r[19:0], s[3:0]};
    end
    return v;
  endfunction : shiftIn

  // ---------------- link domain (sclk), sequence cleared by deselect ----------------
  wire logic linkRst = csN | rst; // deselect ends the frame without a clock edge
  sfcd_phase_t phaseQ, phaseD; // sequencer phase
  sfcd_info_t infoQ, infoD; // shape of the current command
  logic [5:0] cntQ, cntD; // cycles left in address or dummy phase
  logic [7:0] opQ, opD; // opcode shifter
  logic [23:0] addrQ, addrD; // address, also the running read pointer
  logic [7:0] dinQ, dinD; // data-in shifter
  logic [2:0] bitPosQ, bitPosD; // bit position within the current byte
  logic [2:0] laneW; // lanes moved on this edge
  sfcd_step_t step; // next phase choice
  logic [8:0] stS; // status and sleep flag seen on sclk

  // frame summary, kept after deselect for the core side; cleared by rst and restarted in the next frame's opcode phase
  sfcd_kind_t holdKindQ, holdKindD;
  logic [23:0] holdAddrQ;
  logic [7:0] holdDataQ, holdDataD;
  logic holdAlignQ, holdStageQ, holdGotQ, holdGotD, holdOverQ, holdOverD;

  sfcd_stream_if #(.W(8)) wrS ();
  sfcd_stream_if #(.W(8)) rdS ();

  wire logic byteDone = bitPosD == 3'd0;
  wire logic isProg = infoQ.kind == K_PROG_PAGE || infoQ.kind == K_PROG_QUAD;
  assign wrS.valid = phaseQ == PH_DIN && byteDone && isProg;
  assign wrS.data = dinD;

  // next-state of the link sequencer, one step per rising sclk edge
  always_comb begin
    phaseD = phaseQ;
    infoD = infoQ;
    cntD = cntQ;
    opD = opQ;
    addrD = addrQ;
    dinD = dinQ;
    step = '{ph: PH_STBY, cnt: '0};
    unique case (phaseQ)
      PH_ADDR, PH_DUMMY: laneW = infoQ.addrW;
      PH_DIN: laneW = infoQ.dinW;
      PH_DOUT: laneW = infoQ.doutW;
      default: laneW = LW1;
    endcase
    bitPosD = bitPosQ + laneW;
    unique case (phaseQ)
      PH_CMD: begin
        opD = {opQ[6:0], sioIn[0]};
        if (bitPosQ == 3'd7) begin
          infoD = cmdDecode(opD, stS[8]);
          step = nextStep(infoD, 2'd0);
          phaseD = infoD.ok ? step.ph : PH_STBY;
          cntD = step.cnt;
        end
      end
      PH_ADDR: begin
        addrD = shiftIn(addrQ, sioIn, infoQ.addrW);
        cntD = cntQ - 6'd1;
        if (cntQ == 6'd1) begin
          step = nextStep(infoQ, 2'd1);
          phaseD = step.ph;
          cntD = step.cnt;
        end
      end
      PH_DUMMY: begin
        cntD = cntQ - 6'd1;
        if (cntQ == 6'd1) begin
          step = nextStep(infoQ, 2'd2);
          phaseD = step.ph;
          cntD = step.cnt;
        end
      end
      PH_DIN: dinD = 8'(shiftIn({16'h0000, dinQ}, sioIn, infoQ.dinW));
      PH_DOUT: begin
        if (byteDone) begin
          addrD = addrQ + 24'h000001; // next byte of a stream
        end
      end
      PH_STBY: begin
      end
    endcase
  end

  // frame summary next values
  always_comb begin
    holdKindD = holdKindQ;
    holdDataD = holdDataQ;
    holdGotD = holdGotQ;
    holdOverD = holdOverQ;
    if (phaseQ == PH_CMD) begin
      holdKindD = (bitPosQ == 3'd7 && infoD.ok) ? infoD.kind : K_NONE;
      holdGotD = 1'b0;
      holdOverD = 1'b0;
    end else if (phaseQ == PH_DIN && byteDone) begin
      if (!holdGotQ) begin
        holdDataD = dinD; // first data byte, the new status value
      end
      holdGotD = 1'b1;
      holdOverD = holdOverQ | (wrS.valid & ~wrS.ready); // full fifo spoils the page
    end
  end

  // sequencer registers
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      phaseQ <= PH_CMD;
      infoQ <= '0;
      cntQ <= '0;
      opQ <= '0;
      addrQ <= '0;
      dinQ <= '0;
      bitPosQ <= '0;
    end else begin
      phaseQ <= phaseD;
      infoQ <= infoD;
      cntQ <= cntD;
      opQ <= opD;
      addrQ <= addrD;
      dinQ <= dinD;
      bitPosQ <= bitPosD;
    end
  end

  // frame summary registers, updated on every edge so the last edge wins
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      holdKindQ <= K_NONE;
      holdAddrQ <= '0;
      holdDataQ <= '0;
      holdAlignQ <= 1'b0;
      holdStageQ <= 1'b0;
      holdGotQ <= 1'b0;
      holdOverQ <= 1'b0;
    end else begin
      holdKindQ <= holdKindD;
      holdAddrQ <= addrD;
      holdDataQ <= holdDataD;
      holdAlignQ <= byteDone;
      holdStageQ <= phaseD != PH_CMD && phaseD != PH_ADDR;
      holdGotQ <= holdGotD;
      holdOverQ <= holdOverD;
    end
  end

  assign memAddr = addrQ;

  // ---------------- output driver, falling sclk edge ----------------
  logic [7:0] outShQ; // bits still to send of the current byte
  logic [3:0] outLeftQ; // count of those bits
  logic [7:0] nextByte; // byte that starts on this edge
  wire logic [7:0] srcByte = (outLeftQ == 4'd0) ? nextByte : outShQ;
  wire logic [2:0] oW = infoQ.doutW;

  // byte source per command
  always_comb begin
    unique case (infoQ.kind)
      K_STAT_RD: nextByte = stS[7:0];
      K_READ_ID: begin
        unique case (addrQ[1:0])
          2'd0: nextByte = MFR_ID;
          2'd1: nextByte = MEM_TYPE_ID;
          2'd2: nextByte = DEV_ID;
          default: nextByte = 8'h00;
        endcase
      end
      K_RD_NORM, K_RD_FAST, K_RD_DUAL, K_RD_QUAD: nextByte = memRdData;
      K_WAKE_SIG: nextByte = SIG_ID;
      K_IDP_1, K_IDP_2, K_IDP_4: nextByte = addrQ[0] ? DEV_ID : MFR_ID;
      default: nextByte = 8'h00;
    endcase
  end

  // drive on the falling edge; off outside data-out phase
  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      sioOut <= '0;
      sioOe <= '0;
      outShQ <= '0;
      outLeftQ <= '0;
    end else if (phaseQ == PH_DOUT) begin
      outShQ <= 8'(srcByte << oW);
      outLeftQ <= ((outLeftQ == 4'd0) ? 4'd8 : outLeftQ) - {1'b0, oW};
      if (oW == LW4) begin
        sioOut <= srcByte[7:4];
        sioOe <= 4'hf;
      end else if (oW == LW2) begin
        sioOut <= {2'b00, srcByte[7:6]};
        sioOe <= 4'h3;
      end else begin
        sioOut <= {2'b00, srcByte[7], 1'b0};
        sioOe <= 4'h2;
      end
    end else begin
      sioOut <= '0;
      sioOe <= '0;
      outLeftQ <= '0;
    end
  end

  // ---------------- core domain (clk) ----------------
  logic selS, selPrevQ; // select seen on clk; idles low like its reset, so no false commit
  logic welQ, welD, wipQ, wipD, sleepQ, sleepD, qeQ, qeD, srwdQ, srwdD;
  logic [3:0] bpQ, bpD;
  logic startAct, dropAct;
  wire logic [7:0] statusW = {srwdQ, qeQ, bpQ, welQ, wipQ};
  wire logic commit = ~selS & selPrevQ; // frame just ended
  wire logic okWrite = welQ & ~wipQ & ~sleepQ & holdAlignQ & holdStageQ;
  wire logic progKind = holdKindQ == K_PROG_PAGE || holdKindQ == K_PROG_QUAD;

  sfcd_sync #(.W(1)) uCsSync (.clk(clk), .rst(rst), .d(~csN), .q(selS));
  sfcd_sync #(.W(9)) uStSync (.clk(sclk), .rst(rst), .d({sleepQ, statusW}), .q(stS));

  sfcd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) uFifo (
    .wrClk(sclk), .wrRst(rst), .wr(wrS), .rdClk(clk), .rdRst(rst), .rd(rdS)
  );
  assign rdS.ready = progReady;

  // commit the finished frame
  always_comb begin
    welD = welQ;
    wipD = wipQ;
    sleepD = sleepQ;
    qeD = qeQ;
    srwdD = srwdQ;
    bpD = bpQ;
    startAct = 1'b0;
    dropAct = 1'b0;
    if (actDone) begin
      wipD = 1'b0;
      welD = 1'b0;
    end
    if (commit && holdAlignQ && holdStageQ) begin
      unique case (holdKindQ)
        K_SET_LATCH: welD = ~sleepQ;
        K_CLR_LATCH: welD = 1'b0;
        K_STAT_WR: begin
          if (okWrite && holdGotQ) begin
            {srwdD, qeD, bpD} = holdDataQ[ST_SRWD:ST_BP_LO];
            welD = 1'b0;
          end
        end
        K_PROG_PAGE, K_PROG_QUAD: startAct = okWrite & holdGotQ & ~holdOverQ;
        K_WIPE_SMALL, K_WIPE_32K, K_WIPE_64K: startAct = okWrite;
        K_WIPE_ALL: startAct = okWrite & (bpQ[2:0] == 3'b000);
        K_SLEEP: sleepD = 1'b1;
        K_WAKE_SIG: sleepD = 1'b0;
        default: begin
        end
      endcase
    end
    if (startAct) begin
      wipD = 1'b1;
    end
    dropAct = commit & progKind & ~startAct; // rejected page: bytes must be dropped
  end

  // core registers; all outputs from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selPrevQ <= 1'b0;
      welQ <= 1'b0;
      wipQ <= 1'b0;
      sleepQ <= 1'b0;
      qeQ <= 1'b0;
      srwdQ <= 1'b0;
      bpQ <= BP_RST;
      blocksLocked <= LOCK_ALL_RST;
      actValid <= 1'b0;
      actKind <= '0;
      actAddr <= '0;
      progDrop <= 1'b0;
    end else begin
      selPrevQ <= selS;
      welQ <= welD;
      wipQ <= wipD;
      sleepQ <= sleepD;
      qeQ <= qeD;
      srwdQ <= srwdD;
      bpQ <= bpD;
      actValid <= startAct;
      progDrop <= dropAct;
      if (startAct) begin
        actKind <= holdKindQ;
        actAddr <= holdAddrQ;
      end
    end
  end

  assign progData = rdS.data;
  assign progValid = rdS.valid;
  assign busy = wipQ;
  assign deepSleep = sleepQ;

endmodule : sfcd_top

// [testbench/sfcd_props.sv]
// port checker bound to the decoder top
`timescale 1ns/1ps
module sfcd_props import sfcd_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic [3:0] sioOe,
  input wire logic progDrop,
  input wire logic actValid,
  input wire logic [4:0] actKind,
  input wire logic actDone,
  input wire logic busy,
  input wire logic blocksLocked
);
  // a commit while the frame is still open is too early
  sequence s_selAct;
    !csN ##[1:2] actValid;
  endsequence
  a_commit_late: assert property (@(posedge clk) disable iff (rst) not s_selAct)
    else $error("commit too close to select");
  a_oe_desel: assert property (@(posedge clk) disable iff (rst) csN |-> sioOe == 4'h0)
    else $error("lanes driven while deselected");
  a_lock_held: assert property (@(posedge clk) disable iff (rst) blocksLocked)
    else $error("blocks unlocked");
  a_act_pulse: assert property (@(posedge clk) disable iff (rst) actValid |=> !actValid)
    else $error("start longer than one clock");
  a_busy_set: assert property (@(posedge clk) disable iff (rst) actValid |=> busy)
    else $error("start without busy");
  a_busy_clear: assert property (@(posedge clk) disable iff (rst) actDone |=> !busy)
    else $error("busy after done");
  a_act_kind: assert property (@(posedge clk) disable iff (rst) actValid |-> actKind inside
    {K_PROG_PAGE, K_PROG_QUAD, K_WIPE_SMALL, K_WIPE_32K, K_WIPE_64K, K_WIPE_ALL})
    else $error("bad action kind");
  a_drop_quiet: assert property (@(posedge clk) disable iff (rst)
    progDrop |=> !actValid [*3]) else $error("start after drop");
endmodule : sfcd_props
bind sfcd_top sfcd_props u_props (.clk(clk), .rst(rst), .csN(csN), .sioOe(sioOe),
  .progDrop(progDrop), .actValid(actValid), .actKind(actKind), .actDone(actDone),
  .busy(busy), .blocksLocked(blocksLocked));

// [testbench/sfcd_host.sv]
// host link model: link clock, select and lanes
`timescale 1ns/1ps
module sfcd_host (
  output logic sclk,
  output logic csN,
  output logic [3:0] sioIn,
  input wire logic [3:0] sioOut
);
  // clock parked low between frames
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sioIn = 4'h0;
  end
  // gap first, so deselect time is always met
  task sel;
    #40 csN = 1'b0;
  endtask : sel
  // one byte on w lanes, msb first; opcodes only as the caller names them
  task xfer(input int w, input logic [7:0] o, output logic [7:0] i);
    i = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      sioIn = (w == 4) ? o[7:4] : (w == 2) ? {2'h0, o[7:6]} : {3'h0, o[7]};
      o = o << w;
      #24;
      i = (w == 4) ? {i[3:0], sioOut} : (w == 2) ? {i[5:0], sioOut[1:0]} : {i[6:0], sioOut[1]};
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask : xfer
  // released lanes show the inverse, not the last value
  task desel;
    #24 csN = 1'b1;
    sioIn = ~sioIn;
  endtask : desel
endmodule : sfcd_host

// [testbench/sfcd_top_tb.sv]
// self-checking bench of the flash command decoder
`timescale 1ns/1ps
module sfcd_top_tb import sfcd_pkg::*; ();
  logic clk, rst, progReady, actDone, s;
  logic sclk, csN, busy, deepSleep, blocksLocked, progValid, progDrop, actValid;
  logic [3:0] sioIn, sioOut, sioOe;
  logic [23:0] memAddr, actAddr;
  logic [7:0] memRdData, progData, rb;
  logic [4:0] actKind;
  logic [7:0] got[$]; // words taken from the fifo
  int errTotal, checkCount, n;
  assign memRdData = memAddr[7:0] ^ 8'h5c; // array stand-in keyed by address
  sfcd_host h (.sclk(sclk), .csN(csN), .sioIn(sioIn), .sioOut(sioOut));
  sfcd_top dut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sioIn(sioIn), .sioOut(sioOut),
    .sioOe(sioOe), .memAddr(memAddr), .memRdData(memRdData), .progData(progData),
    .progValid(progValid), .progReady(progReady), .progDrop(progDrop), .actValid(actValid),
    .actKind(actKind), .actAddr(actAddr), .actDone(actDone), .busy(busy),
    .deepSleep(deepSleep), .blocksLocked(blocksLocked));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (progValid === 1'b1 && progReady) got.push_back(progData);
  task chk(input string nm, input logic [23:0] e, input logic [23:0] a);
    checkCount++;
    if (a !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  task endOfTest;
    if (errTotal == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : endOfTest
  task cmd(input logic [7:0] op);
    h.sel();
    h.xfer(1, op, rb);
    h.desel();
  endtask : cmd
  task adr(input int w, input logic [23:0] a);
    h.xfer(w, a[23:16], rb);
    h.xfer(w, a[15:8], rb);
    h.xfer(w, a[7:0], rb);
  endtask : adr
  task st(input logic [7:0] e, input logic [7:0] m);
    h.sel();
    h.xfer(1, OP_STAT_RD, rb);
    h.xfer(1, 8'h00, rb);
    h.desel();
    chk("status", e, rb & m);
  endtask : st
  // wait for a start, then end it
  task expAct(input logic [4:0] k);
    n = 0;
    while (actValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("actKind", k, actValid === 1'b1 ? actKind : 5'h1f);
    @(negedge clk) actDone = 1'b1;
    @(negedge clk) actDone = 1'b0;
  endtask : expAct
  task noAct;
    s = 1'b0;
    repeat (10) @(negedge clk) s = s | actValid;
    chk("noStart", 0, s);
  endtask : noAct
  // lanes must stay off for a refused frame
  task refused(input logic [7:0] op);
    h.sel();
    h.xfer(1, op, rb);
    h.xfer(1, 8'h00, rb);
    #1 chk("laneOe", 0, sioOe);
    h.desel();
  endtask : refused
  task prog(input logic [7:0] op, input int w, input int c);
    h.sel();
    h.xfer(1, op, rb);
    adr(w, 24'h012300);
    for (int k = 0; k < c; k++) h.xfer(w, 8'ha0 + 8'(k), rb);
    h.desel();
  endtask : prog
  task tStatus;
    st(8'h3c, 8'hff);
    cmd(OP_SET_LATCH);
    st(8'h3e, 8'hff);
    cmd(OP_CLR_LATCH);
    st(8'h3c, 8'hff);
    h.sel();
    h.xfer(1, OP_SET_LATCH, rb);
    h.xfer(4, 8'h00, rb); // two extra edges break alignment
    h.desel();
    st(8'h3c, 8'hff);
  endtask : tStatus
  task tId;
    logic [7:0] op[4] = '{8'h90, 8'hef, 8'hdf, 8'h90};
    int wd[4] = '{1, 2, 4, 1};
    h.sel();
    h.xfer(1, OP_READ_ID, rb);
    for (int k = 0; k < 3; k++) begin
      h.xfer(1, 8'h00, rb);
      chk("idByte", k == 0 ? 8'h5a : k == 1 ? 8'h3c : 8'h13, rb);
    end
    h.desel();
    foreach (op[i]) begin
      h.sel();
      h.xfer(1, op[i], rb);
      adr(1, {23'h0, i == 3});
      h.xfer(wd[i], 8'h00, rb);
      chk("idFirst", i == 3 ? 8'h13 : 8'h5a, rb);
      h.xfer(wd[i], 8'h00, rb);
      chk("idSecond", i == 3 ? 8'h5a : 8'h13, rb);
      h.desel();
    end
  endtask : tId
  task tRead;
    logic [7:0] op[4] = '{8'h03, 8'h0b, 8'hbb, 8'heb};
    int wd[4] = '{1, 1, 2, 4};
    int dm[4] = '{0, 1, 1, 3};
    foreach (op[i]) begin
      h.sel();
      h.xfer(1, op[i], rb);
      adr(wd[i], 24'h000020 + 24'(i));
      repeat (dm[i]) h.xfer(wd[i], 8'h00, rb);
      for (int j = 0; j < 2; j++) begin
        h.xfer(wd[i], 8'h00, rb);
        chk("readData", (8'h20 + 8'(i + j)) ^ 8'h5c, rb);
      end
      h.desel();
    end
  endtask : tRead
  task tProg;
    cmd(OP_SET_LATCH);
    got.delete();
    prog(OP_PROG_PAGE, 1, 2);
    expAct(K_PROG_PAGE);
    chk("actAddr", 24'h012300, actAddr);
    chk("progWords", 2, got.size());
    chk("progData", 8'ha1, got[1]);
    cmd(OP_SET_LATCH);
    prog(OP_PROG_QUAD, 4, 1);
    expAct(K_PROG_QUAD);
    prog(OP_PROG_PAGE, 1, 1);
    noAct();
    @(negedge clk) progReady = 1'b0;
    cmd(OP_SET_LATCH);
    got.delete();
    prog(OP_PROG_PAGE, 1, 18);
    s = 1'b0;
    repeat (8) @(negedge clk) s = s | progDrop;
    chk("progDrop", 1, s);
    noAct();
    @(negedge clk) progReady = 1'b1;
    repeat (40) @(negedge clk);
    chk("drained", FIFO_DEPTH + 1, got.size());
  endtask : tProg
  task tWipe;
    logic [7:0] op[6] = '{8'h20, 8'h52, 8'hd8, 8'h01, 8'h60, 8'hc7};
    logic [4:0] kd[6] = '{K_WIPE_SMALL, K_WIPE_32K, K_WIPE_64K, K_NONE, K_WIPE_ALL, K_WIPE_ALL};
    foreach (op[i]) begin
      cmd(OP_SET_LATCH);
      h.sel();
      h.xfer(1, op[i], rb);
      if (i < 3) adr(1, 24'h034000);
      if (i == 3) h.xfer(1, 8'h00, rb); // protection cleared
      h.desel();
      if (i == 3) begin
        repeat (6) @(negedge clk);
        st(8'h00, 8'hfc);
      end else expAct(kd[i]);
      if (i < 3) chk("wipeAddr", 24'h034000, actAddr);
    end
  endtask : tWipe
  task tSleep;
    cmd(OP_SLEEP);
    repeat (6) @(negedge clk);
    chk("asleep", 1, deepSleep);
    refused(OP_STAT_RD);
    h.sel();
    h.xfer(1, OP_WAKE_SIG, rb);
    adr(1, 24'h0);
    h.xfer(1, 8'h00, rb);
    h.desel();
    chk("signature", 8'h12, rb);
    repeat (6) @(negedge clk);
    chk("awake", 0, deepSleep);
    refused(8'hff);
    st(8'h00, 8'hff);
  endtask : tSleep
  initial begin
    rst = 1'b1;
    progReady = 1'b1;
    actDone = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    tStatus();
    tId();
    tRead();
    tProg();
    tWipe();
    tSleep();
    endOfTest();
  end
  // watchdog well past the expected run
  initial begin
    #400000;
    errTotal++;
    endOfTest();
  end
endmodule : sfcd_top_tb
